// [output_terminal_function_selector.sv]
// Selects which drive condition turns each of four output terminals on.
`timescale 1ns/1ps
`include "otfs_map.svh"
module output_terminal_function_selector (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire otfs_pkg::otfs_status_s driveStatus,
   input wire otfs_pkg::otfs_analog_s analogIn,
   output logic digital_output_one,
   output logic board_relay_contacts,
   output logic second_relay,
   output logic switch_mode_terminal
);
   logic rstMeta;
   logic rstSync;
   otfs_pkg::otfs_code_t sel_reg [4];
   logic [3:0] comm_reg;
   logic [3:0] out_reg;
   logic [3:0] outNext;
   logic ack_reg;
   logic pulseActive;
   logic cycleDonePrev;
   logic [`OTFS_CNT_W-1:0] pulseCnt;
   otfs_pkg::otfs_status_s st;
   logic access;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   assign st = driveStatus;
   assign access = avs_read | avs_write;
   // One wait cycle per access; the request completes on the edge after ack rises.
   // A low enable keeps the wait up, so no write is lost while state is frozen.
   assign avs_waitrequest = access & ~(ack_reg & clkEn);

   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         ack_reg <= 1'b0;
      end else if (clkEn) begin
         ack_reg <= access & ~ack_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         sel_reg[0] <= `OTFS_RST_SEL0;
         sel_reg[1] <= `OTFS_RST_SEL1;
         sel_reg[2] <= `OTFS_RST_SEL2;
         sel_reg[3] <= `OTFS_RST_SEL3;
         comm_reg <= 4'h0;
      end else if (clkEn && avs_write && ack_reg) begin
         case (avs_address)
            `OTFS_OFS_SEL0: sel_reg[0] <= avs_writedata[5:0];
            `OTFS_OFS_SEL1: sel_reg[1] <= avs_writedata[5:0];
            `OTFS_OFS_SEL2: sel_reg[2] <= avs_writedata[5:0];
            `OTFS_OFS_SEL3: sel_reg[3] <= avs_writedata[5:0];
            `OTFS_OFS_COMM: comm_reg <= avs_writedata[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         avs_readdata <= 32'h0;
      end else if (clkEn && avs_read && !ack_reg) begin
         case (avs_address)
            `OTFS_OFS_SEL0: avs_readdata <= {26'h0, sel_reg[0]};
            `OTFS_OFS_SEL1: avs_readdata <= {26'h0, sel_reg[1]};
            `OTFS_OFS_SEL2: avs_readdata <= {26'h0, sel_reg[2]};
            `OTFS_OFS_SEL3: avs_readdata <= {26'h0, sel_reg[3]};
            `OTFS_OFS_COMM: avs_readdata <= {28'h0, comm_reg};
            `OTFS_OFS_STATE: avs_readdata <= {27'h0, pulseActive, out_reg};
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   // Each completed sequencer cycle restarts a 250 ms pulse.
   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         cycleDonePrev <= 1'b0;
         pulseActive <= 1'b0;
         pulseCnt <= '0;
      end else if (clkEn) begin
         cycleDonePrev <= st.stepSequencerCycleDone;
         if (st.stepSequencerCycleDone && !cycleDonePrev) begin
            pulseActive <= 1'b1;
            pulseCnt <= `OTFS_CNT_W'(`OTFS_PULSE_CYC - 1);
         end else if (pulseCnt != '0) begin
            pulseCnt <= pulseCnt - `OTFS_CNT_W'(1);
         end else begin
            pulseActive <= 1'b0;
         end
      end
   end

   generate
      for (genvar i = 0; i < 4; i++) begin : gSel
         always_comb begin
            case (sel_reg[i])
               6'h00: outNext[i] = 1'b0;
               6'h01: outNext[i] = st.running;
               6'h02: outNext[i] = st.faultStop;
               6'h03: outNext[i] = st.freqLevelDetectOne;
               6'h04: outNext[i] = st.freqReached;
               6'h05: outNext[i] = st.running & st.zeroFreq;
               6'h06: outNext[i] = st.motorPreAlarm;
               6'h07: outNext[i] = st.driveOverloadSoon;
               6'h08: outNext[i] = st.setCountReached;
               6'h09: outNext[i] = st.designatedCountReached;
               6'h0A: outNext[i] = st.lengthReached;
               6'h0B: outNext[i] = pulseActive;
               6'h0C: outNext[i] = st.runTimeReached;
               6'h0D: outNext[i] = st.setFreqBeyondLimit
                     & (st.upperLimitReached | st.lowerLimitReached);
               6'h0E: outNext[i] = st.speedMode & st.torqueLimited & st.stallActive;
               6'h0F: outNext[i] = st.suppliesStable & ~st.faultDetected
                     & st.operable;
               6'h10: outNext[i] = analogIn.analogVoltageInputOne
                     > analogIn.analogInputTwo;
               6'h11: outNext[i] = st.upperLimitReached;
               6'h12: outNext[i] = st.running & st.lowerLimitReached;
               6'h13: outNext[i] = st.underVoltage;
               6'h14: outNext[i] = comm_reg[i];
               6'h17: outNext[i] = st.zeroFreq | ~st.running;
               6'h18: outNext[i] = st.powerOnTimeReached;
               6'h19: outNext[i] = st.freqLevelDetectTwo;
               default: outNext[i] = 1'b0;
            endcase
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         out_reg <= 4'h0;
      end else if (clkEn) begin
         out_reg <= outNext;
      end
   end

   assign digital_output_one = out_reg[0];
   assign board_relay_contacts = out_reg[1];
   assign second_relay = out_reg[2];
   assign switch_mode_terminal = out_reg[3];
endmodule

// [otfs_map.svh]
// Register offsets, field layout, reset values and timing counts of the output terminal selector.
`ifndef OTFS_MAP_SVH
`define OTFS_MAP_SVH
`define OTFS_OFS_SEL0 4'h0
`define OTFS_OFS_SEL1 4'h1
`define OTFS_OFS_SEL2 4'h2
`define OTFS_OFS_SEL3 4'h3
`define OTFS_OFS_COMM 4'h4
`define OTFS_OFS_STATE 4'h5
`define OTFS_CODE_W 6
`define OTFS_RST_SEL0 6'h01
`define OTFS_RST_SEL1 6'h02
`define OTFS_RST_SEL2 6'h00
`define OTFS_RST_SEL3 6'h00
`define OTFS_CLK_HZ 100000000
`define OTFS_PULSE_MS 250
`define OTFS_PULSE_CYC ((`OTFS_CLK_HZ / 1000) * `OTFS_PULSE_MS)
`define OTFS_CNT_W 25
`endif

// [otfs_pkg.sv]
// Types shared by the output terminal selector.
package otfs_pkg;
   typedef logic [5:0] otfs_code_t;
   typedef struct packed {
      logic running;
      logic faultStop;
      logic freqLevelDetectOne;
      logic freqReached;
      logic zeroFreq;
      logic motorPreAlarm;
      logic driveOverloadSoon;
      logic setCountReached;
      logic designatedCountReached;
      logic lengthReached;
      logic stepSequencerCycleDone;
      logic runTimeReached;
      logic setFreqBeyondLimit;
      logic torqueLimited;
      logic stallActive;
      logic speedMode;
      logic suppliesStable;
      logic faultDetected;
      logic operable;
      logic upperLimitReached;
      logic lowerLimitReached;
      logic underVoltage;
      logic powerOnTimeReached;
      logic freqLevelDetectTwo;
   } otfs_status_s;
   typedef struct packed {
      logic [11:0] analogVoltageInputOne;
      logic [11:0] analogInputTwo;
   } otfs_analog_s;
endpackage

// [otfs_props.sv]
// Checker for the selector of the digital output and the bus answer.
`timescale 1ns/1ps
module otfs_props (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_address,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire otfs_pkg::otfs_status_s driveStatus,
   input wire otfs_pkg::otfs_analog_s analogIn,
   input wire logic digital_output_one
);
   logic [5:0] sel;
   logic [2:0] up;
   logic rdy;
   logic enPrev;
   // Outputs only follow their condition after an enabled edge.
   assign rdy = up == 3'h7 && enPrev;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Shadow of the first selector, so each code can be tied to its output.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sel <= 6'h01;
         up <= 3'h0;
         enPrev <= 1'b0;
      end else begin
         enPrev <= clkEn;
         if (avs_write && !avs_waitrequest && avs_address == 4'h0) sel <= avs_writedata[5:0];
         if (up != 3'h7) up <= up + 3'h1;
      end
   end
   a_code_off: assert property (rdy && $past(sel) == 6'h00 |-> !digital_output_one)
      else $error("code 0 drove output");
   a_code_run: assert property (rdy && $past(sel) == 6'h01 |->
      digital_output_one == $past(driveStatus.running)) else $error("code 1 wrong");
   a_code_fault: assert property (rdy && $past(sel) == 6'h02 |->
      digital_output_one == $past(driveStatus.faultStop)) else $error("code 2 wrong");
   a_zero_run: assert property (rdy && $past(sel) == 6'h05 |-> digital_output_one ==
      $past(driveStatus.running && driveStatus.zeroFreq)) else $error("code 5 wrong");
   a_zero_any: assert property (rdy && $past(sel) == 6'h17 |-> digital_output_one ==
      $past(driveStatus.zeroFreq || !driveStatus.running)) else $error("code 23 wrong");
   a_analog_cmp: assert property (rdy && $past(sel) == 6'h10 |-> digital_output_one ==
      $past(analogIn.analogVoltageInputOne > analogIn.analogInputTwo))
      else $error("code 16 wrong");
   a_reserved_off: assert property (rdy && $past(sel) inside {6'h15, 6'h16} |->
      !digital_output_one) else $error("reserved code drove output");
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest && clkEn |=>
      !avs_waitrequest || !clkEn) else $error("bus answer late");
endmodule

// [otfs_lamp_model.sv]
// Far side: lamps or relay coils lit by the four output terminals.
`timescale 1ns/1ps
module otfs_lamp_model (
   input wire logic clk_sys,
   input wire logic [3:0] drive,
   output logic [3:0] lit
);
   always_ff @(posedge clk_sys) begin
      lit <= drive;
   end
endmodule

// [output_terminal_function_selector_tb_top.sv]
// Self-checking bench of the output terminal selector.
`timescale 1ns/1ps
module output_terminal_function_selector_tb_top;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest;
   logic clkEn = 1'b1;
   otfs_pkg::otfs_status_s driveStatus = '0;
   otfs_pkg::otfs_analog_s analogIn = {12'h801, 12'h800};
   logic [3:0] outs, lit;
   int err_total = 0;
   int compares = 0;
   always #5 clk_sys = ~clk_sys;
   output_terminal_function_selector output_terminal_function_selector_i (.clk_sys(clk_sys),
      .reset_n(reset_n), .clkEn(clkEn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .driveStatus(driveStatus), .analogIn(analogIn),
      .digital_output_one(outs[0]), .board_relay_contacts(outs[1]),
      .second_relay(outs[2]), .switch_mode_terminal(outs[3]));
   otfs_lamp_model otfs_lamp_model_i (.clk_sys(clk_sys), .drive(outs), .lit(lit));
   task automatic conclude();
      $display("Counts: %0d mismatches in %0d compares", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin
         chk({31'h0, avs_waitrequest}, 32'h0);
         conclude();
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Each code sees all flags set, all set but stopped, then all clear.
   task automatic sweep(input int lo, input int hi);
      logic [5:0] c;
      logic e;
      otfs_pkg::otfs_status_s st;
      for (int k = lo; k <= hi; k++) begin
         c = (k == 27) ? 6'h3F : 6'(k);
         bus(4'h0, 1'b1, {26'h0, c});
         for (int p = 0; p < 3; p++) begin
            st = (p == 2) ? '0 : '1;
            st.running = (p == 0);
            @(posedge clk_sys);
            driveStatus <= st;
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            e = (p == 2) ? (c inside {11, 16, 20, 23}) : !(c inside {0, 15, 21, 22, 26, 63})
               && !(p == 1 && c inside {1, 5, 18});
            chk({31'h0, outs[0]}, {31'h0, e});
         end
      end
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (int a = 0; a < 5; a++) begin
         bus(4'(a), 1'b0, 32'h0);
         chk(q, (a == 0) ? 32'h1 : (a == 1) ? 32'h2 : 32'h0);
      end
      bus(4'hF, 1'b0, 32'h0);
      chk(q, 32'h0);
      bus(4'h4, 1'b1, 32'hF);
      sweep(0, 13);
      sweep(14, 27);
      for (int a = 0; a < 4; a++) begin
         bus(4'(a), 1'b1, 32'hFFFFFFD7);
         bus(4'(a), 1'b0, 32'h0);
         chk(q, 32'h17);
      end
      bus(4'h5, 1'b0, 32'h0);
      chk(q, 32'h1F);
      chk({28'h0, lit}, 32'hF);
      // A low enable must hold every output while the condition changes.
      @(posedge clk_sys);
      clkEn <= 1'b0;
      driveStatus.running <= 1'b1;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({28'h0, outs}, 32'hF);
      @(posedge clk_sys);
      clkEn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({28'h0, outs}, 32'h0);
      conclude();
   end
endmodule
bind output_terminal_function_selector otfs_props otfs_props_i (.clk_sys(clk_sys),
   .reset_n(reset_n), .clkEn(clkEn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_address(avs_address), .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest), .driveStatus(driveStatus), .analogIn(analogIn),
   .digital_output_one(digital_output_one));
